/* comm_sup_pkg.sv */
/*
  Constants, register map and types of the communication timeout supervisor.
  Assumes a 25 MHz APB clock and 32-bit APB data with one register per word.
*/
package comm_sup_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int IDX_W = 12;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_PROTOCOL = 12'h94A;
  localparam logic [IDX_W-1:0] IDX_CARD_FLAGS = 12'h95B;
  localparam logic [IDX_W-1:0] IDX_PWD_STATUS = 12'h95C;
  localparam logic [IDX_W-1:0] IDX_ACTION = 12'h95D;
  localparam logic [IDX_W-1:0] IDX_DETECT_EN = 12'h95E;
  localparam logic [IDX_W-1:0] IDX_DURATION = 12'h95F;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 12'h960;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'h961;
  localparam logic [IDX_W-1:0] IDX_SUP_STATUS = 12'h962;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int FLAG_ADDR_FILTER = 0;
  localparam int FLAG_NET_PARAMS = 1;
  localparam int FLAG_LOGIN_PWD = 2;
  localparam int PWD_SET_BIT = 0;
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_LINK_LOST = 1;
  localparam int IRQ_CARD_DONE = 2;
  localparam int IRQ_W = 3;
  localparam int STAT_LINK_BIT = 2;

  // ****************************************************************
  // Values after reset and limits
  // ****************************************************************
  localparam logic [2:0] CARD_FLAGS_RST = 3'h0;
  localparam logic [1:0] ACTION_RST = 2'h3;
  localparam logic DETECT_EN_RST = 1'b1;
  localparam logic [REG_W-1:0] DURATION_RST = 16'h001E;
  localparam logic [REG_W-1:0] DURATION_MIN = 16'h0001;
  localparam logic [REG_W-1:0] DURATION_MAX = 16'h0258;
  localparam logic [1:0] PROTOCOL_RST = 2'h0;
  localparam logic [1:0] PROTO_MBT = 2'h2;
  localparam logic [1:0] PROTO_ILLEGAL = 2'h3;

  // ****************************************************************
  // Timing: one tenth of a second in clock cycles
  // ****************************************************************
  localparam int TENTH_MS = 100;
  localparam int CLK_KHZ = 25000;
  localparam int TENTH_CYCLES = TENTH_MS * CLK_KHZ;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {ACT_WARN_RUN, ACT_WARN_RAMP, ACT_WARN_COAST, ACT_SILENT} action_t;
  typedef enum logic [1:0] {SUP_IDLE, SUP_WATCH, SUP_TIMED_OUT} sup_state_t;

endpackage : comm_sup_pkg

/* sup_if.sv */
/*
  Signals between the supervisor core, its connection selector and its timer.
  Assumes all three parties run on pclk.
*/
`timescale 1ns/10ps
interface sup_if;
  logic [1:0] proto;
  logic msg_seen;
  logic abort_seen;
  logic restart;
  logic run;
  logic [comm_sup_pkg::REG_W-1:0] duration;
  logic expired;

  modport det (input proto, output msg_seen, output abort_seen);
  modport tmr (input restart, input run, input duration, output expired);
  modport sup (output proto, output restart, output run, output duration,
               input msg_seen, input abort_seen, input expired);
endinterface : sup_if

/* conn_select.sv */
/*
  Picks the supervised connection from the protocol selection and registers
  its message and abort events. Assumes one-cycle event pulses from the card.
*/
`timescale 1ns/10ps
module conn_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic eip_msg_valid,
  input wire logic eip_rst_fin,
  input wire logic eip_fwd_close,
  input wire logic mbt_msg_valid,
  input wire logic mbt_rst_fin,
  sup_if.det bus
);
  logic msg_ff;
  logic nxt_msg;
  logic abort_ff;
  logic nxt_abort;
  logic use_eip;

  always_comb begin
    use_eip = (bus.proto != comm_sup_pkg::PROTO_MBT);
    nxt_msg = use_eip ? eip_msg_valid : mbt_msg_valid;
    // Forward close ends an implicit connection just as a reset does
    nxt_abort = use_eip ? (eip_rst_fin | eip_fwd_close) : mbt_rst_fin;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_ff <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      msg_ff <= nxt_msg;
      abort_ff <= nxt_abort;
    end
  end

  assign bus.msg_seen = msg_ff;
  assign bus.abort_seen = abort_ff;
endmodule : conn_select

/* silence_timer.sv */
/*
  Counts tenths of a second of silence and pulses expired at the programmed
  duration. Assumes duration never reads zero (the core clamps it).
*/
`timescale 1ns/10ps
module silence_timer #(
  parameter int TICK_CYCLES = comm_sup_pkg::TENTH_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  sup_if.tmr bus
);
  localparam int PW = $clog2(TICK_CYCLES + 1);

  logic [PW-1:0] pre_ff;
  logic [PW-1:0] nxt_pre;
  logic [comm_sup_pkg::REG_W-1:0] ten_ff;
  logic [comm_sup_pkg::REG_W-1:0] nxt_ten;
  logic exp_ff;
  logic nxt_exp;

  always_comb begin
    nxt_pre = pre_ff;
    nxt_ten = ten_ff;
    nxt_exp = 1'b0;
    if (bus.restart || !bus.run) begin
      nxt_pre = '0;
      nxt_ten = '0;
    end else if (pre_ff == PW'(TICK_CYCLES - 1)) begin
      nxt_pre = '0;
      if (ten_ff != 16'hFFFF) begin
        nxt_ten = ten_ff + 16'h0001;
      end
      nxt_exp = (nxt_ten >= bus.duration);
    end else begin
      nxt_pre = pre_ff + PW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= '0;
      ten_ff <= '0;
      exp_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      ten_ff <= nxt_ten;
      exp_ff <= nxt_exp;
    end
  end

  assign bus.expired = exp_ff;
endmodule : silence_timer

/* comm_timeout_supervisor.sv */
/*
  Communication card supervisor: APB register file, card flags, password
  status, timeout state machine, reaction outputs and interrupt.
  Assumes card inputs synchronous to pclk and events as one-cycle pulses.
*/
`timescale 1ns/10ps
module comm_timeout_supervisor #(
  parameter int TENTH_CYCLES = comm_sup_pkg::TENTH_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [comm_sup_pkg::ADDR_W-1:0] paddr,
  input wire logic [comm_sup_pkg::DATA_W-1:0] pwdata,
  output logic [comm_sup_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_up,
  input wire logic eip_msg_valid,
  input wire logic eip_rst_fin,
  input wire logic eip_fwd_close,
  input wire logic mbt_msg_valid,
  input wire logic mbt_rst_fin,
  input wire logic ip_addr_written,
  input wire logic password_entered,
  input wire logic card_update_done,
  input wire logic password_configured,
  output logic addr_filter_en,
  output logic card_update_req,
  output logic timeout_warn,
  output logic ramp_stop_req,
  output logic coast_stop_req,
  output logic irq
);

  // ****************************************************************
  // Address decode helpers
  // ****************************************************************
  function automatic logic [comm_sup_pkg::IDX_W-1:0] reg_index(
    input logic [comm_sup_pkg::ADDR_W-1:0] a
  );
    return a[comm_sup_pkg::IDX_W+1:2];
  endfunction : reg_index

  function automatic logic is_mapped(input logic [comm_sup_pkg::ADDR_W-1:0] a);
    logic [comm_sup_pkg::IDX_W-1:0] idx;
    idx = reg_index(a);
    if (a[1:0] != 2'h0 || a[comm_sup_pkg::ADDR_W-1:comm_sup_pkg::IDX_W+2] != '0) begin
      return 1'b0;
    end
    return (idx == comm_sup_pkg::IDX_PROTOCOL) ||
           (idx >= comm_sup_pkg::IDX_CARD_FLAGS && idx <= comm_sup_pkg::IDX_SUP_STATUS);
  endfunction : is_mapped

  // ****************************************************************
  // Declarations
  // ****************************************************************
  sup_if link_bus ();

  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic [comm_sup_pkg::DATA_W-1:0] prdata_ff;
  logic [comm_sup_pkg::DATA_W-1:0] nxt_prdata;
  logic wr_en;
  logic [comm_sup_pkg::IDX_W-1:0] idx;

  logic [2:0] flags_ff;
  logic [2:0] nxt_flags;
  logic pwd_ff;
  logic [1:0] proto_ff;
  logic [1:0] nxt_proto;
  comm_sup_pkg::action_t action_ff;
  comm_sup_pkg::action_t nxt_action;
  logic det_en_ff;
  logic nxt_det_en;
  logic [comm_sup_pkg::REG_W-1:0] dur_ff;
  logic [comm_sup_pkg::REG_W-1:0] nxt_dur;
  logic [comm_sup_pkg::REG_W-1:0] wr_dur;
  logic req_ff;

  comm_sup_pkg::sup_state_t state_ff;
  comm_sup_pkg::sup_state_t nxt_state;
  logic link_prev_ff;
  logic timeout_evt;

  logic [comm_sup_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [comm_sup_pkg::IRQ_W-1:0] nxt_irq_stat;
  logic [comm_sup_pkg::IRQ_W-1:0] irq_mask_ff;
  logic [comm_sup_pkg::IRQ_W-1:0] nxt_irq_mask;
  logic [comm_sup_pkg::IRQ_W-1:0] irq_evt;

  logic warn_ff;
  logic ramp_ff;
  logic coast_ff;
  logic irq_ff;
  logic nxt_warn;
  logic nxt_ramp;
  logic nxt_coast;
  logic nxt_irq;

  // ****************************************************************
  // Sub-blocks
  // ****************************************************************
  conn_select u_conn_select (
    .pclk(pclk),
    .presetn(presetn),
    .eip_msg_valid(eip_msg_valid),
    .eip_rst_fin(eip_rst_fin),
    .eip_fwd_close(eip_fwd_close),
    .mbt_msg_valid(mbt_msg_valid),
    .mbt_rst_fin(mbt_rst_fin),
    .bus(link_bus.det)
  );

  silence_timer #(
    .TICK_CYCLES(TENTH_CYCLES)
  ) u_silence_timer (
    .pclk(pclk),
    .presetn(presetn),
    .bus(link_bus.tmr)
  );

  assign link_bus.proto = proto_ff;
  assign link_bus.duration = dur_ff;
  assign link_bus.run = (state_ff == comm_sup_pkg::SUP_WATCH) && det_en_ff;
  assign link_bus.restart = link_bus.msg_seen || (state_ff != comm_sup_pkg::SUP_WATCH);

  // ****************************************************************
  // APB slave: no wait state, read data registered in the setup cycle
  // ****************************************************************
  always_comb begin
    idx = reg_index(paddr);
    nxt_pready = psel && !penable;
    nxt_pslverr = psel && !penable && !is_mapped(paddr);
    nxt_prdata = prdata_ff;
    if (psel && !penable && !pwrite) begin
      nxt_prdata = '0;
      unique case (idx)
        comm_sup_pkg::IDX_PROTOCOL: nxt_prdata[1:0] = proto_ff;
        comm_sup_pkg::IDX_CARD_FLAGS: nxt_prdata[2:0] = flags_ff;
        comm_sup_pkg::IDX_PWD_STATUS: nxt_prdata[comm_sup_pkg::PWD_SET_BIT] = pwd_ff;
        comm_sup_pkg::IDX_ACTION: nxt_prdata[1:0] = action_ff;
        comm_sup_pkg::IDX_DETECT_EN: nxt_prdata[0] = det_en_ff;
        comm_sup_pkg::IDX_DURATION: nxt_prdata[comm_sup_pkg::REG_W-1:0] = dur_ff;
        comm_sup_pkg::IDX_IRQ_STATUS: nxt_prdata[comm_sup_pkg::IRQ_W-1:0] = irq_stat_ff;
        comm_sup_pkg::IDX_IRQ_MASK: nxt_prdata[comm_sup_pkg::IRQ_W-1:0] = irq_mask_ff;
        comm_sup_pkg::IDX_SUP_STATUS: begin
          nxt_prdata[1:0] = state_ff;
          nxt_prdata[comm_sup_pkg::STAT_LINK_BIT] = link_up;
        end
        default: nxt_prdata = '0;
      endcase
    end
  end

  // Writes land only at the completing access edge of a mapped address
  assign wr_en = psel && penable && pready_ff && pwrite && !pslverr_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // ****************************************************************
  // Configuration registers and card flags
  // ****************************************************************
  always_comb begin
    nxt_flags = flags_ff;
    nxt_proto = proto_ff;
    nxt_action = action_ff;
    nxt_det_en = det_en_ff;
    nxt_dur = dur_ff;
    wr_dur = pwdata[comm_sup_pkg::REG_W-1:0];
    if (wr_en) begin
      unique case (idx)
        comm_sup_pkg::IDX_CARD_FLAGS: nxt_flags = pwdata[2:0];
        // An illegal protocol code is dropped, the old selection stays
        comm_sup_pkg::IDX_PROTOCOL: begin
          if (pwdata[1:0] != comm_sup_pkg::PROTO_ILLEGAL) begin
            nxt_proto = pwdata[1:0];
          end
        end
        comm_sup_pkg::IDX_ACTION: nxt_action = comm_sup_pkg::action_t'(pwdata[1:0]);
        comm_sup_pkg::IDX_DETECT_EN: nxt_det_en = pwdata[0];
        // Clamp keeps the timer from a zero or overlong interval
        comm_sup_pkg::IDX_DURATION: nxt_dur = (wr_dur < comm_sup_pkg::DURATION_MIN) ?
          comm_sup_pkg::DURATION_MIN : (wr_dur > comm_sup_pkg::DURATION_MAX) ?
          comm_sup_pkg::DURATION_MAX : wr_dur;
        default: nxt_flags = nxt_flags;
      endcase
    end
    if (card_update_done) begin
      nxt_flags[comm_sup_pkg::FLAG_NET_PARAMS] = 1'b0;
      nxt_flags[comm_sup_pkg::FLAG_LOGIN_PWD] = 1'b0;
    end
    // Set after clear so a new request in the done cycle survives
    if (ip_addr_written) begin
      nxt_flags[comm_sup_pkg::FLAG_NET_PARAMS] = 1'b1;
    end
    if (password_entered) begin
      nxt_flags[comm_sup_pkg::FLAG_LOGIN_PWD] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= comm_sup_pkg::CARD_FLAGS_RST;
      req_ff <= 1'b0;
      pwd_ff <= 1'b0;
      proto_ff <= comm_sup_pkg::PROTOCOL_RST;
      action_ff <= comm_sup_pkg::action_t'(comm_sup_pkg::ACTION_RST);
      det_en_ff <= comm_sup_pkg::DETECT_EN_RST;
      dur_ff <= comm_sup_pkg::DURATION_RST;
    end else begin
      flags_ff <= nxt_flags;
      req_ff <= nxt_flags[comm_sup_pkg::FLAG_NET_PARAMS] |
                nxt_flags[comm_sup_pkg::FLAG_LOGIN_PWD];
      pwd_ff <= password_configured;
      proto_ff <= nxt_proto;
      action_ff <= nxt_action;
      det_en_ff <= nxt_det_en;
      dur_ff <= nxt_dur;
    end
  end

  // ****************************************************************
  // Timeout state machine
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      comm_sup_pkg::SUP_IDLE: begin
        if (det_en_ff) begin
          nxt_state = comm_sup_pkg::SUP_WATCH;
        end
      end
      comm_sup_pkg::SUP_WATCH: begin
        if (!det_en_ff) begin
          nxt_state = comm_sup_pkg::SUP_IDLE;
        end else if (!link_up || link_bus.abort_seen ||
                     (link_bus.expired && !link_bus.msg_seen)) begin
          nxt_state = comm_sup_pkg::SUP_TIMED_OUT;
        end
      end
      comm_sup_pkg::SUP_TIMED_OUT: begin
        // Traffic on a live link ends the fault and rearms supervision
        if (!det_en_ff) begin
          nxt_state = comm_sup_pkg::SUP_IDLE;
        end else if (link_bus.msg_seen && link_up) begin
          nxt_state = comm_sup_pkg::SUP_WATCH;
        end
      end
      default: nxt_state = comm_sup_pkg::SUP_IDLE;
    endcase
    timeout_evt = (nxt_state == comm_sup_pkg::SUP_TIMED_OUT) &&
                  (state_ff != comm_sup_pkg::SUP_TIMED_OUT);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= comm_sup_pkg::SUP_IDLE;
      link_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      link_prev_ff <= link_up;
    end
  end

  // ****************************************************************
  // Interrupt status (write one to clear, event wins) and mask
  // ****************************************************************
  always_comb begin
    irq_evt = '0;
    irq_evt[comm_sup_pkg::IRQ_TIMEOUT] = timeout_evt;
    irq_evt[comm_sup_pkg::IRQ_LINK_LOST] = link_prev_ff && !link_up;
    irq_evt[comm_sup_pkg::IRQ_CARD_DONE] = card_update_done;
    nxt_irq_stat = irq_stat_ff;
    nxt_irq_mask = irq_mask_ff;
    if (wr_en && idx == comm_sup_pkg::IDX_IRQ_STATUS) begin
      nxt_irq_stat = irq_stat_ff & ~pwdata[comm_sup_pkg::IRQ_W-1:0];
    end
    if (wr_en && idx == comm_sup_pkg::IDX_IRQ_MASK) begin
      nxt_irq_mask = pwdata[comm_sup_pkg::IRQ_W-1:0];
    end
    nxt_irq_stat = nxt_irq_stat | irq_evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // ****************************************************************
  // Reaction outputs, registered from next state for one-cycle latency
  // ****************************************************************
  always_comb begin
    nxt_warn = (nxt_state == comm_sup_pkg::SUP_TIMED_OUT) &&
               (nxt_action != comm_sup_pkg::ACT_SILENT);
    nxt_ramp = (nxt_state == comm_sup_pkg::SUP_TIMED_OUT) &&
               (nxt_action == comm_sup_pkg::ACT_WARN_RAMP);
    nxt_coast = (nxt_state == comm_sup_pkg::SUP_TIMED_OUT) &&
                (nxt_action == comm_sup_pkg::ACT_WARN_COAST);
    nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_ff <= 1'b0;
      ramp_ff <= 1'b0;
      coast_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      warn_ff <= nxt_warn;
      ramp_ff <= nxt_ramp;
      coast_ff <= nxt_coast;
      irq_ff <= nxt_irq;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign addr_filter_en = flags_ff[comm_sup_pkg::FLAG_ADDR_FILTER];
  assign card_update_req = req_ff;
  assign timeout_warn = warn_ff;
  assign ramp_stop_req = ramp_ff;
  assign coast_stop_req = coast_ff;
  assign irq = irq_ff;

endmodule : comm_timeout_supervisor

/* comm_timeout_supervisor_props.sv */
/*
  Port checker for the communication timeout supervisor.
  Assumes one pclk domain and a bind onto every supervisor instance.
*/
`timescale 1ns/10ps
module comm_timeout_supervisor_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic eip_msg_valid,
  input wire logic mbt_msg_valid,
  input wire logic ip_addr_written,
  input wire logic password_entered,
  input wire logic card_update_done,
  input wire logic addr_filter_en,
  input wire logic card_update_req,
  input wire logic timeout_warn,
  input wire logic ramp_stop_req,
  input wire logic coast_stop_req
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  logic wr_acc;
  logic any_msg;
  assign wr_acc = psel && penable && pwrite;
  assign any_msg = eip_msg_valid || mbt_msg_valid;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RAMP_WARN: assert property (ramp_stop_req |-> timeout_warn && !coast_stop_req)
    else $error("ramp stop without warning");
  AST_COAST_WARN: assert property (coast_stop_req |-> timeout_warn && !ramp_stop_req)
    else $error("coast stop without warning");
  // Only a message or a register write may end a reaction
  AST_WARN_HOLD: assert property ($fell(timeout_warn) |-> $past(any_msg, 2) || $past(any_msg, 3)
    || $past(any_msg, 4) || $past(wr_acc) || $past(wr_acc, 2) || $past(wr_acc, 3))
    else $error("warning dropped without cause");
  AST_FILTER: assert property (!$stable(addr_filter_en) |-> $past(wr_acc))
    else $error("filter enable moved without a write");
  AST_ADDR_SET: assert property (ip_addr_written |=> card_update_req)
    else $error("address write did not request an update");
  AST_PWD_SET: assert property (password_entered |=> card_update_req)
    else $error("password entry did not request an update");
  AST_UPD_DONE: assert property (card_update_done && !ip_addr_written && !password_entered
    && !wr_acc |=> !card_update_req)
    else $error("update request survived completion");
  AST_UPD_CAUSE: assert property ($rose(card_update_req) |->
    $past(ip_addr_written || password_entered || wr_acc))
    else $error("update request rose without cause");
  AST_PREADY: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("access not answered in one cycle");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error outside an answer");
endmodule : comm_timeout_supervisor_props

bind comm_timeout_supervisor comm_timeout_supervisor_props i_props (.pclk, .presetn, .psel,
  .penable, .pwrite, .pready, .pslverr, .eip_msg_valid, .mbt_msg_valid, .ip_addr_written,
  .password_entered, .card_update_done, .addr_filter_en, .card_update_req, .timeout_warn,
  .ramp_stop_req, .coast_stop_req);

/* net_master_model.sv */
/*
  Network master seen from the card: periodic data messages, aborts, link.
  Assumes the bench steers talk, link_ok and abort at pclk edges.
*/
`timescale 1ns/10ps
module net_master_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] talk,
  input wire logic link_ok,
  input wire logic [1:0] abort,
  output logic link_up,
  output logic eip_msg_valid,
  output logic eip_rst_fin,
  output logic eip_fwd_close,
  output logic mbt_msg_valid,
  output logic mbt_rst_fin
);
  logic [1:0] cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 2'h0;
    end else begin
      cnt_ff <= (cnt_ff == 2'h2) ? 2'h0 : cnt_ff + 2'h1;
    end
  end
  // A message every third cycle, none while the link is down
  assign link_up = link_ok;
  assign eip_msg_valid = talk[0] && link_ok && (cnt_ff == 2'h0);
  assign mbt_msg_valid = talk[1] && link_ok && (cnt_ff == 2'h0);
  assign eip_rst_fin = abort[0];
  assign mbt_rst_fin = abort[0];
  assign eip_fwd_close = abort[1];
endmodule : net_master_model

/* comm_timeout_supervisor_tb.sv */
/*
  Self-checking bench of the supervisor: APB tasks and sequenced tests.
  Assumes the checker is bound and a short tenth of four cycles.
*/
`timescale 1ns/10ps
module comm_timeout_supervisor_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, err_seen, link_up, eip_msg_valid, eip_rst_fin, eip_fwd_close;
  logic mbt_msg_valid, mbt_rst_fin, addr_filter_en, card_update_req, irq;
  logic timeout_warn, ramp_stop_req, coast_stop_req;
  logic [2:0] card_ev = 3'h0;
  logic pwd_cfg = 1'b0;
  logic link_ok = 1'b1;
  logic [1:0] talk = 2'h0;
  logic [1:0] abort = 2'h0;
  int err_count = 0;
  int n_compared = 0;
  always #20 pclk = ~pclk;

  comm_timeout_supervisor #(.TENTH_CYCLES(4)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .link_up, .eip_msg_valid, .eip_rst_fin,
    .eip_fwd_close, .mbt_msg_valid, .mbt_rst_fin, .ip_addr_written(card_ev[0]),
    .password_entered(card_ev[1]), .card_update_done(card_ev[2]), .password_configured(pwd_cfg),
    .addr_filter_en, .card_update_req, .timeout_warn, .ramp_stop_req, .coast_stop_req, .irq);
  net_master_model i_master (.pclk, .presetn, .talk, .link_ok, .abort, .link_up, .eip_msg_valid,
    .eip_rst_fin, .eip_fwd_close, .mbt_msg_valid, .mbt_rst_fin);

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait on a dead bus
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rchk(input string nm, input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(nm, q, exp);
  endtask : rchk
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : wt
  task automatic pulse(input logic [1:0] b);
    @(posedge pclk);
    card_ev <= 3'h1 << b;
    @(posedge pclk);
    card_ev <= 3'h0;
  endtask : pulse
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rchk("action", comm_sup_pkg::IDX_ACTION, 32'h3);
    rchk("detect_en", comm_sup_pkg::IDX_DETECT_EN, 32'h1);
    rchk("duration", comm_sup_pkg::IDX_DURATION, 32'h1E);
    rchk("card_flags", comm_sup_pkg::IDX_CARD_FLAGS, 32'h0);
    rchk("pwd_status", comm_sup_pkg::IDX_PWD_STATUS, 32'h0);
    apb(1'b0, 12'h123, 32'h0);
    check("unmapped_err", err_seen, 32'h1);
    check("unmapped_data", q, 32'h0);
    $display("test reset_values done");
    wr(comm_sup_pkg::IDX_CARD_FLAGS, 32'h1);
    wt(1);
    check("addr_filter_en", addr_filter_en, 32'h1);
    wr(comm_sup_pkg::IDX_CARD_FLAGS, 32'h0);
    wr(comm_sup_pkg::IDX_IRQ_STATUS, 32'h7);
    // Each set source in turn, then completion clears it and sets the card-done status bit while irq stays masked
    for (int b = 0; b < 2; b++) begin
      pulse(b);
      wt(1);
      check("update_req", card_update_req, 32'h1);
      rchk("flags_set", comm_sup_pkg::IDX_CARD_FLAGS, 32'h2 << b);
      pulse(2);
      rchk("flags_clr", comm_sup_pkg::IDX_CARD_FLAGS, 32'h0);
    end
    check("irq_masked", irq, 32'h0);
    wr(comm_sup_pkg::IDX_IRQ_MASK, 32'h4);
    wt(1);
    check("irq_on", irq, 32'h1);
    wr(comm_sup_pkg::IDX_IRQ_STATUS, 32'h4);
    wt(1);
    check("irq_clr", irq, 32'h0);
    @(posedge pclk) pwd_cfg <= 1'b1;
    wr(comm_sup_pkg::IDX_PWD_STATUS, 32'h0);
    rchk("pwd_set", comm_sup_pkg::IDX_PWD_STATUS, 32'h1);
    @(posedge pclk) pwd_cfg <= 1'b0;
    wt(3);
    rchk("pwd_clr", comm_sup_pkg::IDX_PWD_STATUS, 32'h0);
    $display("test card_flags done");
    wr(comm_sup_pkg::IDX_DURATION, 32'h0);
    rchk("dur_clamp", comm_sup_pkg::IDX_DURATION, 32'h1);
    wr(comm_sup_pkg::IDX_ACTION, 32'h0);
    @(posedge pclk) talk <= 2'h1;
    wt(30);
    check("warn_live", timeout_warn, 32'h0);
    @(posedge pclk) talk <= 2'h0;
    wt(12);
    check("warn_silent", timeout_warn, 32'h1);
    for (int a = 0; a < 4; a++) begin
      wr(comm_sup_pkg::IDX_ACTION, a);
      wt(2);
      check("warn", timeout_warn, a != 3);
      check("ramp", ramp_stop_req, a == 1);
      check("coast", coast_stop_req, a == 2);
    end
    wr(comm_sup_pkg::IDX_ACTION, 32'h0);
    @(posedge pclk) talk <= 2'h1;
    wr(comm_sup_pkg::IDX_PROTOCOL, 32'h2);
    wt(12);
    check("eip_ignored", timeout_warn, 32'h1);
    @(posedge pclk) talk <= 2'h2;
    wt(12);
    check("mbt_watched", timeout_warn, 32'h0);
    wr(comm_sup_pkg::IDX_DURATION, 32'h1E);
    for (int i = 0; i < 2; i++) begin
      wr(comm_sup_pkg::IDX_PROTOCOL, i ? 32'h1 : 32'h2);
      @(posedge pclk) talk <= i ? 2'h1 : 2'h2;
      wt(12);
      check("warn_live", timeout_warn, 32'h0);
      @(posedge pclk) talk <= 2'h0;
      abort <= i ? 2'h2 : 2'h1;
      @(posedge pclk) abort <= 2'h0;
      wt(3);
      check("warn_abort", timeout_warn, 32'h1);
    end
    wr(comm_sup_pkg::IDX_PROTOCOL, 32'h3);
    rchk("proto_kept", comm_sup_pkg::IDX_PROTOCOL, 32'h1);
    @(posedge pclk) talk <= 2'h1;
    wt(12);
    @(posedge pclk) link_ok <= 1'b0;
    wt(2);
    check("warn_link", timeout_warn, 32'h1);
    rchk("sup_status", comm_sup_pkg::IDX_SUP_STATUS, 32'h2);
    rchk("irq_status", comm_sup_pkg::IDX_IRQ_STATUS, 32'h3);
    wr(comm_sup_pkg::IDX_DETECT_EN, 32'h0);
    wt(2);
    check("warn_disabled", timeout_warn, 32'h0);
    $display("test timeout done");
    end_of_test();
  end
  initial begin
    #400000;
    err_count++;
    end_of_test();
  end
endmodule : comm_timeout_supervisor_tb
